// file: logic/mdtrd_pkg.sv
package mdtrd_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_NET = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DST_LO = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DST_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LEN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_KEY = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_KSRC_LO = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_KSRC_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h28;

  // ****************************************
  // Field layout and widths
  // ****************************************
  localparam int MODE_W = 2;
  localparam int OPT_W = 3;
  localparam int LVL_W = 3;
  localparam int RATE_W = 6;
  localparam int UNITS_W = 4;
  localparam int OCTET_W = 8;
  localparam int NETID_W = 16;
  localparam int WORD_W = 32;
  localparam int ADDR64_W = 64;
  localparam int CNT_W = 8;
  localparam int PTR_W = 7;
  localparam int RES_W = 3;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_DST_LSB = 2;
  localparam int CTRL_OPT_LSB = 4;
  localparam int CTRL_LVL_LSB = 7;
  localparam int CTRL_KMODE_LSB = 10;
  localparam int CTRL_RATE_LSB = 12;
  localparam int CTRL_BURST_BIT = 18;
  localparam int CTRL_CACK_BIT = 19;
  localparam int CTRL_CNACK_BIT = 20;
  localparam int CTRL_UNITS_LSB = 21;
  localparam int LEN_TAG_LSB = 8;
  localparam int CMD_SUBMIT_BIT = 0;
  localparam int CMD_FLUSH_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CODE_LSB = 1;
  localparam int STAT_TAG_LSB = 8;
  localparam int STAT_CNT_LSB = 16;
  localparam int OPT_ACK_BIT = 0;
  localparam int OPT_SLOT_BIT = 1;
  localparam int OPT_INDIRECT_BIT = 2;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [CNT_W-1:0] MAX_PAYLOAD_OCTETS = 8'h7F;
  localparam logic [UNITS_W-1:0] UNITS_RESET = 4'h1;
  localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_ONE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_SHORT = 2'h2;
  localparam logic [MODE_W-1:0] MODE_EXT = 2'h3;
  localparam logic [3:0] SHORT_OCTETS = 4'h2;
  localparam logic [3:0] KSRC_SHORT_OCTETS = 4'h4;
  localparam logic [3:0] EXT_OCTETS = 4'h8;

  typedef enum logic [RES_W-1:0] {
    RES_SUCCESS = 3'h0,
    RES_INVALID_ADDRESS = 3'h1,
    RES_INVALID_PARAMETER = 3'h2
  } mdtrd_result_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CHECK = 2'h1,
    ST_ISSUE = 2'h3
  } mdtrd_state_type;

  // Octets of an address field for a given addressing mode
  function automatic logic [3:0] addr_octets(input logic [MODE_W-1:0] mode);
    case (mode)
      MODE_SHORT: addr_octets = SHORT_OCTETS;
      MODE_EXT: addr_octets = EXT_OCTETS;
      default: addr_octets = 4'h0;
    endcase
  endfunction

  // Keep only the low octets of a 64-bit field
  function automatic logic [ADDR64_W-1:0] keep_octets(input logic [ADDR64_W-1:0] v, input logic [3:0] n);
    logic [ADDR64_W-1:0] r;
    r = '0;
    for (int i = 0; i < ADDR64_W / OCTET_W; i++) begin
      if (4'(i) < n) begin
        r[i*OCTET_W +: OCTET_W] = v[i*OCTET_W +: OCTET_W];
      end
    end
    keep_octets = r;
  endfunction

endpackage

// file: logic/mdtrd_check.sv
`timescale 1ns/100ps
module mdtrd_check
  import mdtrd_pkg::*;
(
  input wire logic [MODE_W-1:0] src_mode_in,
  input wire logic [MODE_W-1:0] dst_mode_in,
  input wire logic [LVL_W-1:0] level_in,
  input wire logic [MODE_W-1:0] kmode_in,
  input wire logic [OCTET_W-1:0] kslot_in,
  input wire logic [CNT_W-1:0] count_in,
  input wire logic [CNT_W-1:0] stored_in,
  input wire logic [UNITS_W-1:0] units_in,
  output logic [RES_W-1:0] result_out
);

  // Validity of a request; address fault outranks parameter faults
  always_comb begin
    result_out = RES_SUCCESS;
    if (src_mode_in == MODE_NONE && dst_mode_in == MODE_NONE) begin
      result_out = RES_INVALID_ADDRESS;
    end else if (src_mode_in == MODE_ONE) begin
      result_out = RES_INVALID_PARAMETER;
    end else if (count_in > MAX_PAYLOAD_OCTETS || count_in != stored_in) begin
      result_out = RES_INVALID_PARAMETER;
    end else if (level_in != '0 && kmode_in != MODE_NONE && kslot_in == '0) begin
      result_out = RES_INVALID_PARAMETER;
    end else if (units_in == '0 || CNT_W'(units_in) > count_in) begin
      result_out = RES_INVALID_PARAMETER;
    end else if (units_in > UNITS_RESET && dst_mode_in != MODE_SHORT && dst_mode_in != MODE_EXT) begin
      result_out = RES_INVALID_PARAMETER;
    end
  end

endmodule

// file: logic/mdtrd_top.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module mdtrd_top
  import mdtrd_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [WORD_W-1:0] PWDATA_IN,
  input wire logic [PTR_W-1:0] PAYLOAD_RD_ADDR_IN,
  output logic [WORD_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic RESULT_VALID_OUT,
  output logic [RES_W-1:0] RESULT_CODE_OUT,
  output logic [OCTET_W-1:0] RESULT_TAG_OUT,
  output logic FRAME_VALID_OUT,
  output logic [3:0] SRC_ADDR_OCTETS_OUT,
  output logic [3:0] DST_ADDR_OCTETS_OUT,
  output logic BROADCAST_OUT,
  output logic [NETID_W-1:0] DST_NET_ID_OUT,
  output logic [ADDR64_W-1:0] DST_ADDR_OUT,
  output logic [CNT_W-1:0] PAYLOAD_COUNT_OUT,
  output logic [OCTET_W-1:0] PAYLOAD_TAG_OUT,
  output logic [UNITS_W-1:0] PACKED_UNITS_OUT,
  output logic ACK_REQUEST_OUT,
  output logic GUARANTEED_SLOT_OUT,
  output logic INDIRECT_OUT,
  output logic SECURITY_ENABLED_OUT,
  output logic [LVL_W-1:0] PROTECTION_LEVEL_OUT,
  output logic [MODE_W-1:0] KEY_ID_MODE_OUT,
  output logic [ADDR64_W-1:0] KEY_ORIGINATOR_OUT,
  output logic [OCTET_W-1:0] KEY_SLOT_OUT,
  output logic [RATE_W-1:0] PHY_RATE_OUT,
  output logic BURST_OUT,
  output logic COLOUR_ACK_OUT,
  output logic COLOUR_NACK_OUT,
  output logic [OCTET_W-1:0] PAYLOAD_RD_DATA_OUT
);

  // ****************************************
  // Declarations
  // ****************************************
  mdtrd_state_type state_q;
  logic [MODE_W-1:0] src_mode_q;
  logic [MODE_W-1:0] dst_mode_q;
  logic [OPT_W-1:0] opt_q;
  logic [LVL_W-1:0] level_q;
  logic [MODE_W-1:0] kmode_q;
  logic [RATE_W-1:0] rate_q;
  logic burst_q;
  logic cack_q;
  logic cnack_q;
  logic [UNITS_W-1:0] units_q;
  logic [NETID_W-1:0] net_id_q;
  logic [ADDR64_W-1:0] dst_addr_q;
  logic [CNT_W-1:0] count_q;
  logic [OCTET_W-1:0] tag_q;
  logic [OCTET_W-1:0] kslot_q;
  logic [ADDR64_W-1:0] ksrc_q;
  logic [CNT_W-1:0] stored_q;
  logic [OCTET_W-1:0] payload_mem [0:MAX_PAYLOAD_OCTETS-1];
  logic [RES_W-1:0] check_d;
  logic [RES_W-1:0] check_q;
  logic [WORD_W-1:0] rd_d;
  logic map_ok;
  logic busy;
  logic wr_acc;
  logic cfg_we;
  logic go;
  logic flush;
  logic push;
  logic [MODE_W-1:0] kmode_eff;

  // ****************************************
  // Bus decode
  // ****************************************
  // Writes land only at the access edge with ready high
  assign wr_acc = CE_IN & PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT & map_ok;
  assign busy = (state_q != ST_IDLE);
  // Config held steady while a request is in flight
  assign cfg_we = wr_acc & ~busy;
  assign go = cfg_we & (PADDR_IN == ADDR_CMD) & PWDATA_IN[CMD_SUBMIT_BIT];
  assign flush = cfg_we & (PADDR_IN == ADDR_CMD) & PWDATA_IN[CMD_FLUSH_BIT];
  assign push = cfg_we & (PADDR_IN == ADDR_DATA) & (stored_q < MAX_PAYLOAD_OCTETS);
  // Key mode means nothing without protection
  assign kmode_eff = (level_q == '0) ? MODE_NONE : kmode_q;

  // Read mux and map check
  always_comb begin
    rd_d = '0;
    map_ok = 1'b1;
    case (PADDR_IN)
      ADDR_CTRL: begin
        rd_d[CTRL_SRC_LSB +: MODE_W] = src_mode_q;
        rd_d[CTRL_DST_LSB +: MODE_W] = dst_mode_q;
        rd_d[CTRL_OPT_LSB +: OPT_W] = opt_q;
        rd_d[CTRL_LVL_LSB +: LVL_W] = level_q;
        rd_d[CTRL_KMODE_LSB +: MODE_W] = kmode_q;
        rd_d[CTRL_RATE_LSB +: RATE_W] = rate_q;
        rd_d[CTRL_BURST_BIT] = burst_q;
        rd_d[CTRL_CACK_BIT] = cack_q;
        rd_d[CTRL_CNACK_BIT] = cnack_q;
        rd_d[CTRL_UNITS_LSB +: UNITS_W] = units_q;
      end
      ADDR_NET: rd_d[NETID_W-1:0] = net_id_q;
      ADDR_DST_LO: rd_d = dst_addr_q[WORD_W-1:0];
      ADDR_DST_HI: rd_d = dst_addr_q[ADDR64_W-1:WORD_W];
      ADDR_LEN: begin
        rd_d[CNT_W-1:0] = count_q;
        rd_d[LEN_TAG_LSB +: OCTET_W] = tag_q;
      end
      ADDR_KEY: rd_d[OCTET_W-1:0] = kslot_q;
      ADDR_KSRC_LO: rd_d = ksrc_q[WORD_W-1:0];
      ADDR_KSRC_HI: rd_d = ksrc_q[ADDR64_W-1:WORD_W];
      ADDR_DATA, ADDR_CMD: rd_d = '0;
      ADDR_STATUS: begin
        rd_d[STAT_BUSY_BIT] = busy;
        rd_d[STAT_CODE_LSB +: RES_W] = RESULT_CODE_OUT;
        rd_d[STAT_TAG_LSB +: OCTET_W] = RESULT_TAG_OUT;
        rd_d[STAT_CNT_LSB +: CNT_W] = stored_q;
      end
      default: map_ok = 1'b0;
    endcase
  end

  // Answer prepared in the setup cycle: zero wait states, flop outputs
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= '0;
    end else if (CE_IN) begin
      PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~map_ok;
      PRDATA_OUT <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rd_d : '0;
    end
  end

  // ****************************************
  // Request registers
  // ****************************************
  // Control word: modes, options, security and link flags
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      src_mode_q <= MODE_NONE;
      dst_mode_q <= MODE_NONE;
      opt_q <= '0;
      level_q <= '0;
      kmode_q <= MODE_NONE;
      rate_q <= '0;
      burst_q <= 1'b0;
      cack_q <= 1'b0;
      cnack_q <= 1'b0;
      units_q <= UNITS_RESET;
    end else if (cfg_we && PADDR_IN == ADDR_CTRL) begin
      src_mode_q <= PWDATA_IN[CTRL_SRC_LSB +: MODE_W];
      dst_mode_q <= PWDATA_IN[CTRL_DST_LSB +: MODE_W];
      opt_q <= PWDATA_IN[CTRL_OPT_LSB +: OPT_W];
      level_q <= PWDATA_IN[CTRL_LVL_LSB +: LVL_W];
      kmode_q <= PWDATA_IN[CTRL_KMODE_LSB +: MODE_W];
      rate_q <= PWDATA_IN[CTRL_RATE_LSB +: RATE_W];
      burst_q <= PWDATA_IN[CTRL_BURST_BIT];
      cack_q <= PWDATA_IN[CTRL_CACK_BIT];
      cnack_q <= PWDATA_IN[CTRL_CNACK_BIT];
      units_q <= PWDATA_IN[CTRL_UNITS_LSB +: UNITS_W];
    end
  end

  // Addressing, length, tag and key words
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      net_id_q <= '0;
      dst_addr_q <= '0;
      count_q <= '0;
      tag_q <= '0;
      kslot_q <= '0;
      ksrc_q <= '0;
    end else if (cfg_we) begin
      case (PADDR_IN)
        ADDR_NET: net_id_q <= PWDATA_IN[NETID_W-1:0];
        ADDR_DST_LO: dst_addr_q[WORD_W-1:0] <= PWDATA_IN;
        ADDR_DST_HI: dst_addr_q[ADDR64_W-1:WORD_W] <= PWDATA_IN;
        ADDR_LEN: begin
          count_q <= PWDATA_IN[CNT_W-1:0];
          tag_q <= PWDATA_IN[LEN_TAG_LSB +: OCTET_W];
        end
        ADDR_KEY: kslot_q <= PWDATA_IN[OCTET_W-1:0];
        ADDR_KSRC_LO: ksrc_q[WORD_W-1:0] <= PWDATA_IN;
        ADDR_KSRC_HI: ksrc_q[ADDR64_W-1:WORD_W] <= PWDATA_IN;
        default: net_id_q <= net_id_q;
      endcase
    end
  end

  // ****************************************
  // Payload store
  // ****************************************
  // Octets past the maximum are dropped; the length check then refuses
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      stored_q <= '0;
    end else if (flush) begin
      stored_q <= '0;
    end else if (push) begin
      stored_q <= stored_q + 1'b1;
    end
  end

  // Array and read port carry no reset
  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      if (push) begin
        payload_mem[stored_q[PTR_W-1:0]] <= PWDATA_IN[OCTET_W-1:0];
      end
      PAYLOAD_RD_DATA_OUT <= payload_mem[PAYLOAD_RD_ADDR_IN];
    end
  end

  // ****************************************
  // Validation and sequencing
  // ****************************************
  mdtrd_check u_check (
    .src_mode_in(src_mode_q),
    .dst_mode_in(dst_mode_q),
    .level_in(level_q),
    .kmode_in(kmode_q),
    .kslot_in(kslot_q),
    .count_in(count_q),
    .stored_in(stored_q),
    .units_in(units_q),
    .result_out(check_d)
  );

  // Check result latched a cycle early to cut the path to the outputs
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      state_q <= ST_IDLE;
      check_q <= RES_SUCCESS;
    end else if (CE_IN) begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          check_q <= check_d;
          state_q <= ST_ISSUE;
        end
        ST_ISSUE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result report: one pulse per request, tag returned for matching
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      RESULT_VALID_OUT <= 1'b0;
      RESULT_CODE_OUT <= RES_SUCCESS;
      RESULT_TAG_OUT <= '0;
      FRAME_VALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      RESULT_VALID_OUT <= (state_q == ST_ISSUE);
      FRAME_VALID_OUT <= (state_q == ST_ISSUE) && (check_q == RES_SUCCESS);
      if (state_q == ST_ISSUE) begin
        RESULT_CODE_OUT <= check_q;
        RESULT_TAG_OUT <= tag_q;
      end
    end
  end

  // ****************************************
  // Decoded controls for frame building
  // ****************************************
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      SRC_ADDR_OCTETS_OUT <= '0;
      DST_ADDR_OCTETS_OUT <= '0;
      BROADCAST_OUT <= 1'b0;
      DST_NET_ID_OUT <= '0;
      DST_ADDR_OUT <= '0;
      PAYLOAD_COUNT_OUT <= '0;
      PAYLOAD_TAG_OUT <= '0;
      PACKED_UNITS_OUT <= '0;
      ACK_REQUEST_OUT <= 1'b0;
      GUARANTEED_SLOT_OUT <= 1'b0;
      INDIRECT_OUT <= 1'b0;
      SECURITY_ENABLED_OUT <= 1'b0;
      PROTECTION_LEVEL_OUT <= '0;
      KEY_ID_MODE_OUT <= MODE_NONE;
      KEY_ORIGINATOR_OUT <= '0;
      KEY_SLOT_OUT <= '0;
      PHY_RATE_OUT <= '0;
      BURST_OUT <= 1'b0;
      COLOUR_ACK_OUT <= 1'b0;
      COLOUR_NACK_OUT <= 1'b0;
    end else if (CE_IN && state_q == ST_ISSUE && check_q == RES_SUCCESS) begin
      SRC_ADDR_OCTETS_OUT <= addr_octets(src_mode_q);
      DST_ADDR_OCTETS_OUT <= addr_octets(dst_mode_q);
      BROADCAST_OUT <= (dst_mode_q == MODE_ONE);
      DST_NET_ID_OUT <= net_id_q;
      DST_ADDR_OUT <= keep_octets(dst_addr_q, addr_octets(dst_mode_q));
      PAYLOAD_COUNT_OUT <= count_q;
      PAYLOAD_TAG_OUT <= tag_q;
      PACKED_UNITS_OUT <= units_q;
      ACK_REQUEST_OUT <= opt_q[OPT_ACK_BIT];
      GUARANTEED_SLOT_OUT <= opt_q[OPT_SLOT_BIT];
      INDIRECT_OUT <= opt_q[OPT_INDIRECT_BIT];
      SECURITY_ENABLED_OUT <= (level_q != '0);
      PROTECTION_LEVEL_OUT <= level_q;
      KEY_ID_MODE_OUT <= kmode_eff;
      KEY_ORIGINATOR_OUT <= keep_octets(ksrc_q,
        (kmode_eff == MODE_SHORT) ? KSRC_SHORT_OCTETS : addr_octets(kmode_eff));
      KEY_SLOT_OUT <= (kmode_eff == MODE_NONE) ? '0 : kslot_q;
      PHY_RATE_OUT <= rate_q;
      BURST_OUT <= burst_q;
      COLOUR_ACK_OUT <= cack_q;
      COLOUR_NACK_OUT <= cnack_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_submit;
    go;
  endsequence

  sequence s_report;
    ##[1:1000] RESULT_VALID_OUT && RESULT_TAG_OUT == tag_q;
  endsequence

  a_tag_report: assert property (s_submit |-> s_report)
    else $error("Submitted request got no tagged result");
  a_src_octets: assert property (FRAME_VALID_OUT |->
    SRC_ADDR_OCTETS_OUT == ((src_mode_q == MODE_EXT) ? EXT_OCTETS : (src_mode_q == MODE_SHORT) ? SHORT_OCTETS : '0))
    else $error("Source address width wrong");
  a_dst_broadcast: assert property (FRAME_VALID_OUT |-> BROADCAST_OUT == (dst_mode_q == MODE_ONE))
    else $error("Broadcast decode wrong");
  a_dst_short: assert property (FRAME_VALID_OUT && dst_mode_q == MODE_SHORT |->
    DST_ADDR_OUT[ADDR64_W-1:NETID_W] == '0 && DST_ADDR_OUT[NETID_W-1:0] == dst_addr_q[NETID_W-1:0])
    else $error("Short destination address not trimmed");
  a_opt_bits: assert property (FRAME_VALID_OUT |->
    {INDIRECT_OUT, GUARANTEED_SLOT_OUT, ACK_REQUEST_OUT} == opt_q)
    else $error("Option bits misdecoded");
  a_kmode_ignored: assert property (FRAME_VALID_OUT && level_q == '0 |-> KEY_ID_MODE_OUT == MODE_NONE)
    else $error("Key mode kept at level zero");
  a_korig_len: assert property (FRAME_VALID_OUT && KEY_ID_MODE_OUT == MODE_SHORT |->
    KEY_ORIGINATOR_OUT[ADDR64_W-1:WORD_W] == '0)
    else $error("Key originator longer than four octets");
  a_kslot_range: assert property (FRAME_VALID_OUT && KEY_ID_MODE_OUT != MODE_NONE |-> KEY_SLOT_OUT != '0)
    else $error("Key slot zero accepted");
  a_rate_pass: assert property (FRAME_VALID_OUT |-> PHY_RATE_OUT == rate_q)
    else $error("Rate code not passed");
  a_packed_peer: assert property (FRAME_VALID_OUT && PACKED_UNITS_OUT > UNITS_RESET |-> DST_ADDR_OCTETS_OUT != '0)
    else $error("Packed units without single peer");
  a_both_none: assert property (RESULT_VALID_OUT && src_mode_q == MODE_NONE && dst_mode_q == MODE_NONE |->
    RESULT_CODE_OUT == RES_INVALID_ADDRESS && !FRAME_VALID_OUT)
    else $error("Missing addressing not refused");
  a_len_range: assert property (RESULT_VALID_OUT && count_q > MAX_PAYLOAD_OCTETS |->
    RESULT_CODE_OUT == RES_INVALID_PARAMETER)
    else $error("Oversize payload not refused");
  a_sec_bit: assert property (FRAME_VALID_OUT |-> SECURITY_ENABLED_OUT == (level_q != '0))
    else $error("Security enabled bit wrong");
  a_src_rsvd: assert property (RESULT_VALID_OUT && src_mode_q == MODE_ONE |->
    RESULT_CODE_OUT == RES_INVALID_PARAMETER)
    else $error("Reserved source mode not refused");

endmodule

// file: bench/mdtrd_requester.sv
`timescale 1ns/100ps
// ****************************************
// Requesting entity on the register bus
// ****************************************
module mdtrd_requester
  import mdtrd_pkg::*;
(
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic [WORD_W-1:0] prdata_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [ADDR_W-1:0] paddr_out,
  output logic [WORD_W-1:0] pwdata_out
);
  // Idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = '0;
    pwdata_out = '0;
  end

  // One transfer; released lines show inverted values so stale data never looks live
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                      output logic [WORD_W-1:0] rd, output logic err, output bit ok);
    ok = 1'b0;
    rd = '0;
    err = 1'b0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_in);
      if (pready_in === 1'b1) begin
        ok = 1'b1;
        rd = prdata_in;
        err = pslverr_in;
      end
    end
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

// file: bench/mdtrd_top_bench.sv
`timescale 1ns/100ps
// ****************************************
// Request decoder bench
// ****************************************
module mdtrd_top_bench;
  import mdtrd_pkg::*;
  logic clk, srst, ce, psel, pen, pwr, pready, pslverr, rv, fv, bc, ack, slot, ind, sec, bst, cack, cnack;
  logic [ADDR_W-1:0] paddr;
  logic [WORD_W-1:0] pwdata, prdata, v;
  logic [PTR_W-1:0] rd_ptr;
  logic [2:0] code, lvl;
  logic [3:0] so, dso, units;
  logic [7:0] rtag, cnt, ptag, kslot, pdata;
  logic [15:0] net;
  logic [63:0] dadr, korig;
  logic [1:0] kmode;
  logic [5:0] rate;
  logic e;
  int failures, compares;

  mdtrd_top i_dut (.CLOCK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PAYLOAD_RD_ADDR_IN(rd_ptr), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RESULT_VALID_OUT(rv), .RESULT_CODE_OUT(code),
    .RESULT_TAG_OUT(rtag), .FRAME_VALID_OUT(fv), .SRC_ADDR_OCTETS_OUT(so), .DST_ADDR_OCTETS_OUT(dso),
    .BROADCAST_OUT(bc), .DST_NET_ID_OUT(net), .DST_ADDR_OUT(dadr), .PAYLOAD_COUNT_OUT(cnt),
    .PAYLOAD_TAG_OUT(ptag), .PACKED_UNITS_OUT(units), .ACK_REQUEST_OUT(ack), .GUARANTEED_SLOT_OUT(slot),
    .INDIRECT_OUT(ind), .SECURITY_ENABLED_OUT(sec), .PROTECTION_LEVEL_OUT(lvl), .KEY_ID_MODE_OUT(kmode),
    .KEY_ORIGINATOR_OUT(korig), .KEY_SLOT_OUT(kslot), .PHY_RATE_OUT(rate), .BURST_OUT(bst),
    .COLOUR_ACK_OUT(cack), .COLOUR_NACK_OUT(cnack), .PAYLOAD_RD_DATA_OUT(pdata));

  mdtrd_requester i_req (.clk_in(clk), .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr), .pwdata_out(pwdata));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Wide enough for the longest packed comparison, so no field is cut off
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Bus access; a hung slave ends the run
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    bit ok;
    i_req.xfer(w, a, d, v, e, ok);
    if (!ok) begin
      failures++;
      report_and_stop();
    end
  endtask

  // Control word packing, values within field widths only
  function automatic logic [31:0] mk(input int s, dm, o, l, k, r, b, ca, cn, u);
    return 32'((s << CTRL_SRC_LSB) | (dm << CTRL_DST_LSB) | (o << CTRL_OPT_LSB) | (l << CTRL_LVL_LSB)
      | (k << CTRL_KMODE_LSB) | (r << CTRL_RATE_LSB) | (b << CTRL_BURST_BIT) | (ca << CTRL_CACK_BIT)
      | (cn << CTRL_CNACK_BIT) | (u << CTRL_UNITS_LSB));
  endfunction

  // Submit and wait for the result pulse, bounded; hold keeps the enable low for that many cycles right after the submit write
  task automatic submit(input logic [2:0] exp, input int hold = 0);
    acc(1'b1, ADDR_CMD, 32'h1);
    if (hold > 0) begin
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      check(rv, 1'b0);
      ce <= 1'b1;
    end
    for (int i = 0; i < 10 && rv !== 1'b1; i++) @(posedge clk);
    if (rv !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    check(code, exp);
    check(rtag, 8'h5A);
    check(fv, exp == RES_SUCCESS);
  endtask

  logic [31:0] tc[5];
  logic [2:0] te[5];
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    rd_ptr = '0;
    failures = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    check(rv, 1'b0);
    acc(1'b0, ADDR_STATUS, '0);
    check(v, 32'h0);
    acc(1'b0, 8'h2C, '0);
    check({e, v}, 33'h100000000);
    // Full request: slot bit cleared as no beacon state is known, flags as the requester sets them
    acc(1'b1, ADDR_NET, 32'hBEEF);
    acc(1'b1, ADDR_DST_LO, 32'h89ABCDEF);
    acc(1'b1, ADDR_DST_HI, 32'h01234567);
    acc(1'b1, ADDR_LEN, 32'h5A03);
    acc(1'b1, ADDR_KEY, 32'h07);
    acc(1'b1, ADDR_KSRC_LO, 32'hCAFEF00D);
    acc(1'b1, ADDR_KSRC_HI, 32'h55AA33CC);
    for (int i = 0; i < 3; i++) acc(1'b1, ADDR_DATA, 32'(8'h10 + i));
    acc(1'b1, ADDR_CTRL, mk(2, 3, 5, 5, 2, 42, 1, 1, 0, 1));
    submit(RES_SUCCESS, 3);
    check({so, dso, bc, net, dadr}, {4'h2, 4'h8, 1'b0, 16'hBEEF, 64'h0123456789ABCDEF});
    check({cnt, ptag, units, ack, slot, ind}, {8'h03, 8'h5A, 4'h1, 3'b101});
    check({sec, lvl, kmode, kslot}, {1'b1, 3'h5, 2'h2, 8'h07});
    check(korig, 64'hCAFEF00D);
    check({rate, bst, cack, cnack}, {6'h2A, 3'b110});
    rd_ptr <= 7'h01;
    repeat (3) @(posedge clk);
    check(pdata, 8'h11);
    // Level zero: key fields disregarded, broadcast destination
    acc(1'b1, ADDR_CTRL, mk(3, 1, 0, 0, 3, 63, 0, 0, 1, 1));
    submit(RES_SUCCESS);
    check({sec, kmode, kslot, korig}, 75'h0);
    check({so, dso, bc, dadr, rate, cnack}, {4'h8, 4'h0, 1'b1, 64'h0, 6'h3F, 1'b1});
    tc = '{mk(0, 0, 0, 0, 0, 0, 0, 0, 0, 1), mk(1, 2, 0, 0, 0, 0, 0, 0, 0, 1), mk(2, 2, 0, 0, 0, 0, 0, 0, 0, 0),
      mk(2, 1, 0, 0, 0, 0, 0, 0, 0, 2), mk(2, 2, 0, 0, 0, 0, 0, 0, 0, 3)};
    te = '{RES_INVALID_ADDRESS, RES_INVALID_PARAMETER, RES_INVALID_PARAMETER, RES_INVALID_PARAMETER,
      RES_SUCCESS};
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ADDR_CTRL, tc[i]);
      submit(te[i]);
    end
    check(units, 4'h3);
    // Stated count beyond the payload limit, then the good count back
    acc(1'b1, ADDR_LEN, 32'h5A80);
    submit(RES_INVALID_PARAMETER);
    acc(1'b1, ADDR_LEN, 32'h5A03);
    acc(1'b1, ADDR_KEY, 32'h0);
    acc(1'b1, ADDR_CTRL, mk(2, 2, 0, 1, 1, 0, 0, 0, 0, 1));
    submit(RES_INVALID_PARAMETER);
    // Flushed store no longer matches the stated count
    acc(1'b1, ADDR_CMD, 32'h2);
    acc(1'b1, ADDR_CTRL, mk(2, 2, 0, 0, 0, 0, 0, 0, 0, 1));
    submit(RES_INVALID_PARAMETER);
    acc(1'b0, ADDR_STATUS, '0);
    check(v, 32'h00005A04);
    report_and_stop();
  end
endmodule
